// File: hw/sfr_port_regs.svh
// Purpose: register indices, field positions, reset values and bus codes
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef SFR_PORT_REGS_SVH
`define SFR_PORT_REGS_SVH

// register indices (byte address = index * 4)
`define IDX_TIMER_COUNT 8'h06
`define IDX_PORT_LEVELS 8'h08
`define IDX_PORT_DIR 8'h09
`define IDX_HALT_REQ 8'h0F
`define IDX_SCRATCH0 8'h18
`define IDX_TIMER_CTRL 8'h20

// field positions
`define HALT_BIT 0
`define CLK_SEL_BIT 0
`define PORT_MSB 6

// reset values
`define RST_PORT_DIR 7'h00
`define RST_SCRATCH0 16'h0000
`define RST_CLK_SEL 1'b0

// synchroniser depth on the pin path
`define SYNC_STAGES 2

// bus answer codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hw/sfr_port_pkg.sv
// Purpose: shared types for the port and halt register slice
// Assumes: constants live in sfr_port_regs.svh
// Notes: types only
package sfr_port_pkg;
  typedef logic [11:0] addr_t; // byte address on the register bus
  typedef logic [31:0] word_t; // bus data word
  typedef logic [6:0] pins_t; // one bit per port pin
  typedef logic [7:0] idx_t; // register index
endpackage

// File: hw/pin_sync.sv
// Purpose: two flip-flop synchroniser for the port pin levels
// Assumes: pins are asynchronous to mclk
// Notes: no reset, the levels simply follow the pins
`timescale 1ns/1ps
module pin_sync (
  input wire logic mclk,
  input wire logic ce,
  input wire sfr_port_pkg::pins_t async_in,
  output sfr_port_pkg::pins_t sync_out
);
  import sfr_port_pkg::*;

  pins_t meta_reg; // first stage, read only by the second stage

  // two stages, frozen while the clock enable is low
  always_ff @(posedge mclk) begin
    if (ce) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// File: hw/sfr_port_breakpoint_regs.sv
// Purpose: timer count access, port input/direction, software halt, debug scratch
// Assumes: AXI4-Lite slave on mclk, synchronous active-high reset
// Notes: timer counting and the port output latch live outside this block
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "sfr_port_regs.svh"
module sfr_port_breakpoint_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire sfr_port_pkg::addr_t s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire sfr_port_pkg::word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire sfr_port_pkg::addr_t s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output sfr_port_pkg::word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // timer side
  input wire logic [7:0] timer_count_in,
  output logic timer_load_pulse,
  output logic [7:0] timer_load_value,
  output logic timer_clock_select,
  // port pins
  input wire sfr_port_pkg::pins_t port_pin_in,
  input wire sfr_port_pkg::pins_t port_output_value,
  output sfr_port_pkg::pins_t port_pin_out,
  output sfr_port_pkg::pins_t port_pin_oe_n,
  // emulation block
  output logic emulation_halt_input
);
  import sfr_port_pkg::*;

  // decode a byte address into a register index
  function automatic idx_t addr_idx(input addr_t a);
    addr_idx = a[9:2];
  endfunction

  // true when the index names a register of this slice
  function automatic logic idx_mapped(input idx_t i);
    case (i)
      `IDX_TIMER_COUNT, `IDX_PORT_LEVELS, `IDX_PORT_DIR,
      `IDX_HALT_REQ, `IDX_SCRATCH0, `IDX_TIMER_CTRL: idx_mapped = 1'b1;
      default: idx_mapped = 1'b0;
    endcase
  endfunction

  pins_t port_pin_direction_reg; // direction bits, one per pin
  logic [15:0] debug_scratch_first_reg; // scratch word for debug code
  pins_t port_pin_levels; // synchronised pin levels
  addr_t aw_addr_reg; // held write address
  logic aw_held_reg; // write address taken, waiting for data
  word_t w_data_reg; // held write data
  logic [3:0] w_strb_reg; // held write strobes
  logic w_held_reg; // write data taken, waiting for address
  idx_t rd_idx_reg; // index of the last read, for checking
  logic wr_do; // write commits this cycle
  idx_t wr_idx; // index of the committing write
  logic rd_do; // read address taken this cycle
  idx_t rd_idx; // index of the incoming read
  word_t rd_word; // read mux result

  assign wr_do = ce && aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_idx = addr_idx(aw_addr_reg);
  assign rd_do = ce && s_axi_arvalid && s_axi_arready;
  assign rd_idx = addr_idx(s_axi_araddr);

  // pin levels cross into mclk through two flops
  pin_sync u_pin_sync (
    .mclk(mclk),
    .ce(ce),
    .async_in(port_pin_in),
    .sync_out(port_pin_levels)
  );

  // write address channel: take once, hold until the write commits
  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      s_axi_awready <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_do) begin
        aw_held_reg <= 1'b0;
      end else if (!aw_held_reg && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // write data channel: independent of the address, either order works
  always_ff @(posedge mclk) begin
    if (rst) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_do) begin
        w_held_reg <= 1'b0;
      end else if (!w_held_reg && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response follows both halves; unmapped answers slave error
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (ce) begin
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= idx_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // timer clock select; the counter itself is outside
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_clock_select <= `RST_CLK_SEL;
    end else if (ce && wr_do && wr_idx == `IDX_TIMER_CTRL && w_strb_reg[0]) begin
      timer_clock_select <= w_data_reg[`CLK_SEL_BIT];
    end
  end

  // timer load strobe, only on the system clock source
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_load_pulse <= 1'b0;
      timer_load_value <= 8'h00;
    end else if (ce) begin
      timer_load_pulse <= 1'b0;
      // a write while the slow source runs is dropped but still answered OKAY
      if (wr_do && wr_idx == `IDX_TIMER_COUNT && w_strb_reg[0] &&
          !timer_clock_select) begin
        timer_load_pulse <= 1'b1;
        timer_load_value <= w_data_reg[7:0];
      end
    end
  end

  // direction register, cleared on reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      port_pin_direction_reg <= `RST_PORT_DIR;
    end else if (ce && wr_do && wr_idx == `IDX_PORT_DIR && w_strb_reg[0]) begin
      port_pin_direction_reg <= w_data_reg[`PORT_MSB:0];
    end
  end

  // halt request: one-cycle pulse, never stored for reads
  always_ff @(posedge mclk) begin
    if (rst) begin
      emulation_halt_input <= 1'b0;
    end else if (ce) begin
      // the pulse lands right after the writing access commits
      emulation_halt_input <= wr_do && wr_idx == `IDX_HALT_REQ && w_strb_reg[0] &&
                              w_data_reg[`HALT_BIT];
    end
  end

  // debug scratch word, byte lanes honoured
  always_ff @(posedge mclk) begin
    if (rst) begin
      debug_scratch_first_reg <= `RST_SCRATCH0;
    end else if (ce && wr_do && wr_idx == `IDX_SCRATCH0) begin
      if (w_strb_reg[0]) begin
        debug_scratch_first_reg[7:0] <= w_data_reg[7:0];
      end
      if (w_strb_reg[1]) begin
        debug_scratch_first_reg[15:8] <= w_data_reg[15:8];
      end
    end
  end

  // pin drivers: output value where direction is one, released elsewhere
  always_ff @(posedge mclk) begin
    if (rst) begin
      port_pin_out <= 7'h00;
      port_pin_oe_n <= 7'h7F;
    end else if (ce) begin
      port_pin_out <= port_output_value & port_pin_direction_reg;
      port_pin_oe_n <= ~port_pin_direction_reg;
    end
  end

  // read mux; reserved bits and the halt bit read zero
  always_comb begin
    rd_word = 32'h00000000;
    case (rd_idx)
      `IDX_TIMER_COUNT: rd_word[7:0] = timer_count_in;
      `IDX_PORT_LEVELS: rd_word[`PORT_MSB:0] = port_pin_levels;
      `IDX_PORT_DIR: rd_word[`PORT_MSB:0] = port_pin_direction_reg;
      `IDX_HALT_REQ: rd_word = 32'h00000000;
      `IDX_SCRATCH0: rd_word[15:0] = debug_scratch_first_reg;
      `IDX_TIMER_CTRL: rd_word[`CLK_SEL_BIT] = timer_clock_select;
      default: rd_word = 32'h00000000;
    endcase
  end

  // read channel: one read at a time, answer one cycle after the address
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
      rd_idx_reg <= 8'h00;
    end else if (ce) begin
      if (rd_do) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= idx_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
        rd_idx_reg <= rd_idx;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // commit of a halt-bit write
  sequence halt_write_s;
    wr_do && wr_idx == `IDX_HALT_REQ && w_strb_reg[0] && w_data_reg[`HALT_BIT];
  endsequence

  // commit of a timer count write
  sequence count_write_s;
    wr_do && wr_idx == `IDX_TIMER_COUNT && w_strb_reg[0];
  endsequence

  // read answer for a given index
  sequence read_answer_s(idx_t i);
    s_axi_rvalid && rd_idx_reg == i;
  endsequence

  halt_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    halt_write_s |=> emulation_halt_input)
    else $error("halt write did not raise the emulation input");

  halt_self_clear_a: assert property (@(posedge mclk) disable iff (rst)
    emulation_halt_input && ce && !(wr_do && wr_idx == `IDX_HALT_REQ &&
      w_strb_reg[0] && w_data_reg[`HALT_BIT]) |=> !emulation_halt_input)
    else $error("halt request did not clear itself");

  halt_reads_zero_a: assert property (@(posedge mclk) disable iff (rst)
    read_answer_s(`IDX_HALT_REQ) |-> s_axi_rdata == 32'h00000000)
    else $error("halt register read returned nonzero");

  timer_load_a: assert property (@(posedge mclk) disable iff (rst)
    count_write_s ##0 !timer_clock_select |=>
      timer_load_pulse && timer_load_value == $past(w_data_reg[7:0]))
    else $error("timer load missing or wrong value");

  timer_ignore_a: assert property (@(posedge mclk) disable iff (rst)
    count_write_s ##0 timer_clock_select |=> !timer_load_pulse)
    else $error("timer write accepted on slow clock source");

  pin_release_a: assert property (@(posedge mclk) disable iff (rst)
    ce |=> port_pin_oe_n == ~$past(port_pin_direction_reg))
    else $error("pin enable does not follow direction");

  pin_drive_a: assert property (@(posedge mclk) disable iff (rst)
    ce |=> port_pin_out == $past(port_output_value & port_pin_direction_reg))
    else $error("pin output does not follow output value");

  reserved_zero_a: assert property (@(posedge mclk) disable iff (rst)
    read_answer_s(`IDX_PORT_LEVELS) or read_answer_s(`IDX_PORT_DIR) |->
      s_axi_rdata[31:7] == 25'h0000000)
    else $error("reserved port bits read nonzero");

  reset_clear_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(rst) |-> port_pin_direction_reg == 7'h00 && !emulation_halt_input)
    else $error("reset left direction or halt set");

  levels_sync_a: assert property (@(posedge mclk) disable iff (rst)
    ce ##1 ce |=> port_pin_levels == $past(port_pin_in, 2))
    else $error("pin levels not two stages behind pins");

  levels_read_a: assert property (@(posedge mclk) disable iff (rst)
    rd_do && rd_idx == `IDX_PORT_LEVELS |=> s_axi_rdata[6:0] == $past(port_pin_levels))
    else $error("port input read wrong levels");

  scratch_write_a: assert property (@(posedge mclk) disable iff (rst)
    wr_do && wr_idx == `IDX_SCRATCH0 && w_strb_reg[1:0] == 2'h3 |=>
      debug_scratch_first_reg == $past(w_data_reg[15:0]))
    else $error("scratch register did not store write");

  // direction bits take the low seven data bits of a committed write
  dir_write_a: assert property (@(posedge mclk) disable iff (rst)
    wr_do && wr_idx == `IDX_PORT_DIR && w_strb_reg[0] |=>
      port_pin_direction_reg == $past(w_data_reg[6:0]))
    else $error("direction register did not store write");

  // the write answer comes on the edge after the commit cycle
  write_answer_a: assert property (@(posedge mclk) disable iff (rst)
    wr_do |=> s_axi_bvalid)
    else $error("write response missing after commit");

  // a taken read is answered next cycle, address side closed meanwhile
  read_answer_a: assert property (@(posedge mclk) disable iff (rst)
    rd_do |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing after address taken");
endmodule

// File: sim/far_side_model.sv
// Purpose: stand-in for the timer and the port pin wires beside the register slice
// Assumes: external drivers always hold a level on released pins
// Notes: timer only holds the loaded count, counting is not modelled
`timescale 1ns/1ps
module far_side_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic timer_load_pulse,
  input wire logic [7:0] timer_load_value,
  input wire sfr_port_pkg::pins_t port_pin_out,
  input wire sfr_port_pkg::pins_t port_pin_oe_n,
  input wire sfr_port_pkg::pins_t ext_drive,
  output logic [7:0] timer_count_in,
  output sfr_port_pkg::pins_t port_pin_in
);
  import sfr_port_pkg::*;
  // timer holds the last load, so a read back is predictable
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_count_in <= 8'h00;
    end else if (timer_load_pulse) begin
      timer_count_in <= timer_load_value;
    end
  end
  // wire level per pin: block wins while its enable is low, else the outside driver
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      port_pin_in[i] = port_pin_oe_n[i] ? ext_drive[i] : port_pin_out[i];
    end
  end
endmodule

// File: sim/tb.sv
// Purpose: register-level test of the port, halt, timer and scratch slice
// Assumes: byte address is four times the register index
// Notes: every wait is bounded, a used-up bound ends the run
`timescale 1ns/1ps
`include "sfr_port_regs.svh"
module tb;
  import sfr_port_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, load_p, clk_sel, halt;
  addr_t awaddr = 12'h000, araddr = 12'h000;
  word_t wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic [7:0] tcount, load_v;
  pins_t pin_in, pin_out, oe_n, out_val = 7'h2B, ext = 7'h55;
  int fail_count = 0, total_checks = 0, halt_pulses = 0, load_pulses = 0;
  word_t rd;
  initial forever #5 mclk = ~mclk;
  sfr_port_breakpoint_regs u_dut (.mclk(mclk), .rst(rst), .ce(ce),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .timer_count_in(tcount), .timer_load_pulse(load_p), .timer_load_value(load_v),
    .timer_clock_select(clk_sel), .port_pin_in(pin_in), .port_output_value(out_val),
    .port_pin_out(pin_out), .port_pin_oe_n(oe_n), .emulation_halt_input(halt));
  far_side_model u_far (.mclk(mclk), .rst(rst), .timer_load_pulse(load_p),
    .timer_load_value(load_v), .port_pin_out(pin_out), .port_pin_oe_n(oe_n),
    .ext_drive(ext), .timer_count_in(tcount), .port_pin_in(pin_in));
  // pulse counters, so one-cycle outputs are never missed
  always @(posedge mclk) begin
    if (halt === 1'b1) halt_pulses++;
    if (load_p === 1'b1) load_pulses++;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a bound that runs out is a hang
  task automatic bound(int n);
    if (n >= 200) begin
      fail_count++;
      wrap_up();
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(idx_t i, word_t d, logic [1:0] er);
    int n;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge mclk);
    awvalid <= 1'b1; awaddr <= {2'b00, i, 2'b00}; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    for (n = 0; n < 200 && !(aw_ok && w_ok); n++) begin
      @(posedge mclk);
      if (awvalid && awready === 1'b1) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready === 1'b1) begin w_ok = 1'b1; wvalid <= 1'b0; end
    end
    bound(n);
    for (n = 0; n < 200 && bvalid !== 1'b1; n++) @(posedge mclk);
    bound(n);
    check("bresp", {30'h0, bresp}, {30'h0, er});
    if (!(aw_ok && w_ok)) bound(200);
    @(posedge mclk);
    bready <= 1'b0;
  endtask
  // read: address held until taken, rready held until data seen
  task automatic rdw(idx_t i, logic [1:0] er, output word_t d);
    int n;
    @(posedge mclk);
    arvalid <= 1'b1; araddr <= {2'b00, i, 2'b00}; rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge mclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    bound(n);
    d = rdata;
    check("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask
  task automatic rd_chk(string what, idx_t i, word_t exp);
    rdw(i, `RESP_OKAY, rd);
    check(what, rd, exp);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd_chk("dir reset", `IDX_PORT_DIR, 32'h0);
    rd_chk("halt reset", `IDX_HALT_REQ, 32'h0);
    check("oe_n reset", {25'h0, oe_n}, 32'h7F);
    rd_chk("pins in", `IDX_PORT_LEVELS, 32'h55);
    wr(`IDX_PORT_LEVELS, 32'hFF, `RESP_OKAY); // read-only place ignores the write
    wr(8'hFE, 32'hFF, `RESP_SLVERR); // unmapped place answers an error
    ext <= 7'h2A;
    repeat (4) @(posedge mclk);
    rd_chk("pins follow", `IDX_PORT_LEVELS, 32'h2A);
    wr(`IDX_PORT_DIR, 32'hFF, `RESP_OKAY);
    rd_chk("dir bit7", `IDX_PORT_DIR, 32'h7F);
    check("oe_n all", {25'h0, oe_n}, 32'h00);
    check("pin out", {25'h0, pin_out}, 32'h2B);
    repeat (4) @(posedge mclk);
    rd_chk("driven pins", `IDX_PORT_LEVELS, 32'h2B);
    wr(`IDX_PORT_DIR, 32'h0A, `RESP_OKAY);
    check("oe_n mixed", {25'h0, oe_n}, 32'h75);
    check("out mixed", {25'h0, pin_out}, 32'h0A);
    // outside drives zero where the block drives one, so the two are told apart
    ext <= 7'h55;
    repeat (4) @(posedge mclk);
    rd_chk("mixed pins", `IDX_PORT_LEVELS, 32'h5F);
    // clock enable low: the pin drivers must not move
    ce <= 1'b0;
    out_val <= 7'h04;
    repeat (3) @(posedge mclk);
    check("pin out frozen", {25'h0, pin_out}, 32'h0A);
    ce <= 1'b1;
    repeat (2) @(posedge mclk);
    check("pin out resumed", {25'h0, pin_out}, 32'h00);
    wr(`IDX_HALT_REQ, 32'hFF, `RESP_OKAY);
    check("halt pulse", halt_pulses, 1);
    rd_chk("halt reads 0", `IDX_HALT_REQ, 32'h0);
    wr(`IDX_HALT_REQ, 32'h00, `RESP_OKAY);
    check("no halt on 0", halt_pulses, 1);
    wr(`IDX_TIMER_COUNT, 32'hA5, `RESP_OKAY);
    rd_chk("count load", `IDX_TIMER_COUNT, 32'hA5);
    wr(`IDX_TIMER_CTRL, 32'h1, `RESP_OKAY);
    check("slow clock", {31'h0, clk_sel}, 32'h1);
    wr(`IDX_TIMER_COUNT, 32'h3C, `RESP_OKAY);
    check("ignored load", load_pulses, 1);
    rd_chk("count kept", `IDX_TIMER_COUNT, 32'hA5);
    wr(`IDX_TIMER_CTRL, 32'h0, `RESP_OKAY);
    wr(`IDX_TIMER_COUNT, 32'h3C, `RESP_OKAY);
    rd_chk("count again", `IDX_TIMER_COUNT, 32'h3C);
    wr(`IDX_SCRATCH0, 32'h1234_ABCD, `RESP_OKAY);
    rd_chk("scratch", `IDX_SCRATCH0, 32'hABCD);
    rdw(8'hFF, `RESP_SLVERR, rd);
    check("unmapped", rd, 32'h0);
    // second reset in mid-run with direction set
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_chk("dir rereset", `IDX_PORT_DIR, 32'h0);
    check("oe_n rereset", {25'h0, oe_n}, 32'h7F);
    wrap_up();
  end
endmodule
